// [hw/cmi_pkg.sv]
// Function
// - one pending bit per message object
// - pending bits read-only, follow object condition
// - read-write enable bit per message object
// - quantum equals prescale plus one clocks
// - quantum is unit of all segments
// - prescaler not reset; software programs first
// - reserved bits undefined; never write ones
// - reset clears status and enable bits
`default_nettype none
package cmi_pkg;
	// ----------------------------------------------------------------
	// register addresses in special-function space
	// ----------------------------------------------------------------
	localparam logic [7:0] CMI_ADDR_PRESCALE = 8'hB4;
	localparam logic [7:0] CMI_ADDR_STAT_HI = 8'hBA;
	localparam logic [7:0] CMI_ADDR_STAT_LO = 8'hBB;
	localparam logic [7:0] CMI_ADDR_EN_HI = 8'hC2;
	localparam logic [7:0] CMI_ADDR_EN_LO = 8'hC3;
	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int CMI_NUM_OBJ = 15;
	localparam int CMI_HI_BITS = 7;
	localparam int CMI_PRE_LSB = 1;
	localparam int CMI_PRE_W = 6;
	localparam logic [14:0] CMI_EN_RESET = 15'h0000;
	// reserved bits read as zero here
	localparam logic [7:0] CMI_RSVD_READ = 8'h00;
	// ----------------------------------------------------------------
	// register bus request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cmi_sfr_req_t;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] ref_a);
		addr_hit = (a == ref_a);
	endfunction
endpackage : cmi_pkg
`default_nettype wire

// [hw/cmi_quantum_div.sv]
`default_nettype none
module cmi_quantum_div
	import cmi_pkg::*;
#(
	parameter int PRE_W = CMI_PRE_W
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [PRE_W-1:0] prescale,
	output logic quantum_tick
);
	// ----------------------------------------------------------------
	// quantum divider: one pulse every prescale+1 clocks
	// ----------------------------------------------------------------
	logic [PRE_W-1:0] cnt_q;
	logic [PRE_W-1:0] cnt_d;
	logic wrap;
	assign wrap = (cnt_q >= prescale);
	assign cnt_d = wrap ? '0 : cnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
	// counter holds at zero while stopped so first quantum is full
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (!run)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
	// tick is registered
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			quantum_tick <= 1'b0;
		else
			quantum_tick <= run & wrap;
	end
endmodule // cmi_quantum_div
`default_nettype wire

// [hw/cmi_irq_merge.sv]
`default_nettype none
module cmi_irq_merge
	import cmi_pkg::*;
#(
	parameter int NUM_OBJ = CMI_NUM_OBJ
)(
	input wire logic [NUM_OBJ-1:0] pending,
	input wire logic [NUM_OBJ-1:0] enable,
	output logic any_req
);
	// ----------------------------------------------------------------
	// request when any object is both pending and enabled
	// ----------------------------------------------------------------
	assign any_req = |(pending & enable);
endmodule // cmi_irq_merge
`default_nettype wire

// [hw/cmi_top.sv]
`default_nettype none
module cmi_top
	import cmi_pkg::*;
#(
	parameter int NUM_OBJ = CMI_NUM_OBJ,
	parameter int PRE_W = CMI_PRE_W
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	// sfr access from the core
	input wire cmi_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// per-object conditions raised by message object logic
	input wire logic [NUM_OBJ-1:0] object_irq_cond,
	// controller enable bit from general_control_reg
	input wire logic ctrl_enable,
	// outputs
	output logic object_irq_req,
	output logic quantum_tick,
	output logic [PRE_W-1:0] rate_prescale_value
);
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire hit_pre = addr_hit(sfr_req.addr, CMI_ADDR_PRESCALE);
	wire hit_sh = addr_hit(sfr_req.addr, CMI_ADDR_STAT_HI);
	wire hit_sl = addr_hit(sfr_req.addr, CMI_ADDR_STAT_LO);
	wire hit_eh = addr_hit(sfr_req.addr, CMI_ADDR_EN_HI);
	wire hit_el = addr_hit(sfr_req.addr, CMI_ADDR_EN_LO);
	// timing writes only take effect while the controller is off
	wire wr_pre = sfr_req.wr & hit_pre & ~ctrl_enable;
	wire wr_eh = sfr_req.wr & hit_eh;
	wire wr_el = sfr_req.wr & hit_el;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [NUM_OBJ-1:0] object_irq_pending_q; // mirror of conditions
	logic [NUM_OBJ-1:0] object_irq_enable_q;
	logic [NUM_OBJ-1:0] object_irq_enable_d;
	logic [PRE_W-1:0] prescale_q; // no reset value
	logic [7:0] rdata_d;
	logic irq_comb;
	logic tick_w;

	// status follows the object condition; writes never reach it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			object_irq_pending_q <= '0;
		else
			object_irq_pending_q <= object_irq_cond;
	end

	// enable register, byte split high and low
	assign object_irq_enable_d = {
		wr_eh ? sfr_req.wdata[CMI_HI_BITS-1:0]
			: object_irq_enable_q[NUM_OBJ-1:8],
		wr_el ? sfr_req.wdata : object_irq_enable_q[7:0]};
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			object_irq_enable_q <= CMI_EN_RESET;
		else
			object_irq_enable_q <= object_irq_enable_d;
	end

	// prescaler deliberately left out of reset
	always_ff @(posedge ref_clk)
	begin
		if (wr_pre)
			prescale_q <= sfr_req.wdata[CMI_PRE_LSB +: PRE_W];
	end

	// ----------------------------------------------------------------
	// read mux; reserved bits read zero
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_d = CMI_RSVD_READ;
		if (hit_pre)
			rdata_d[CMI_PRE_LSB +: PRE_W] = prescale_q;
		else if (hit_sh)
			rdata_d[CMI_HI_BITS-1:0] = object_irq_pending_q[NUM_OBJ-1:8];
		else if (hit_sl)
			rdata_d = object_irq_pending_q[7:0];
		else if (hit_eh)
			rdata_d[CMI_HI_BITS-1:0] = object_irq_enable_q[NUM_OBJ-1:8];
		else if (hit_el)
			rdata_d = object_irq_enable_q[7:0];
	end

	// ----------------------------------------------------------------
	// sub blocks
	// ----------------------------------------------------------------
	cmi_irq_merge #(.NUM_OBJ(NUM_OBJ)) u_merge (
		.pending(object_irq_pending_q),
		.enable(object_irq_enable_q),
		.any_req(irq_comb)
	);
	// quantum drives every bit segment downstream
	cmi_quantum_div #(.PRE_W(PRE_W)) u_div (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(ctrl_enable),
		.prescale(prescale_q),
		.quantum_tick(tick_w)
	);
	assign quantum_tick = tick_w;

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sfr_rdata <= '0;
			object_irq_req <= 1'b0;
			rate_prescale_value <= '0;
		end
		else
		begin
			sfr_rdata <= sfr_req.rd ? rdata_d : 8'h00;
			object_irq_req <= irq_comb;
			rate_prescale_value <= prescale_q;
		end
	end
endmodule // cmi_top
`default_nettype wire

// [tb/cmi_top_assertions.sv]
`default_nettype none
module cmi_top_assertions
	import cmi_pkg::*;
#(
	parameter int NUM_OBJ = 15,
	parameter int PRE_W = 6
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire cmi_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic [NUM_OBJ-1:0] object_irq_cond,
	input wire logic ctrl_enable,
	input wire logic object_irq_req,
	input wire logic quantum_tick,
	input wire logic [PRE_W-1:0] rate_prescale_value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------
	// gap between ticks, reckoned only once a tick was seen
	// ------------------------------------------------
	logic [7:0] gap_q;
	logic seen_q;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_q <= 8'h00;
			seen_q <= 1'b0;
		end
		else
		begin
			gap_q <= quantum_tick ? 8'h00 : gap_q + 8'h01;
			seen_q <= ctrl_enable && (seen_q || quantum_tick);
		end
	end
	a_status_low_read: assert property (sfr_req.rd &&
		sfr_req.addr == CMI_ADDR_STAT_LO && $stable(object_irq_cond)
		|=> sfr_rdata == $past(object_irq_cond[7:0])) else $error("low read");
	a_status_high_read: assert property (sfr_req.rd &&
		sfr_req.addr == CMI_ADDR_STAT_HI && $stable(object_irq_cond)
		|=> sfr_rdata == {1'b0, $past(object_irq_cond[14:8])})
		else $error("high read");
	a_idle_rdata_zero: assert property (!sfr_req.rd |=>
		sfr_rdata == 8'h00) else $error("idle rdata");
	a_unmapped_zero: assert property (sfr_req.rd &&
		sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00) else $error("unmapped");
	a_no_cond_no_req: assert property ((object_irq_cond == '0)[*2]
		|=> !object_irq_req) else $error("stray request");
	a_tick_off_idle: assert property (!ctrl_enable[*2] |=>
		!quantum_tick) else $error("tick while off");
	a_tick_gap_exact: assert property (quantum_tick && seen_q &&
		ctrl_enable |-> gap_q == 8'(rate_prescale_value)) else $error("gap");
	a_prescale_locked: assert property (ctrl_enable[*3] |->
		$stable(rate_prescale_value)) else $error("prescale moved");
	c_req: cover property (object_irq_req);
	c_tick: cover property (quantum_tick && seen_q);
	c_lock: cover property (sfr_req.wr && ctrl_enable);
endmodule // cmi_top_assertions
bind cmi_top cmi_top_assertions #(.NUM_OBJ(NUM_OBJ), .PRE_W(PRE_W))
	cmi_top_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ctrl_enable(ctrl_enable),
	.object_irq_cond(object_irq_cond), .object_irq_req(object_irq_req),
	.quantum_tick(quantum_tick), .rate_prescale_value(rate_prescale_value));
`default_nettype wire

// [tb/cmi_top_tb.sv]
`default_nettype none
module cmi_top_tb;
	import cmi_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	cmi_sfr_req_t sfr_req = '0;
	logic [14:0] cond = 15'h0000;
	logic en = 1'b0;
	logic [7:0] rdata;
	logic req;
	logic tick;
	logic [5:0] pre;
	int fail_count = 0;
	int checked = 0;
	int n;
	always #10 ref_clk = ~ref_clk;
	cmi_top cmi_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req),
		.sfr_rdata(rdata), .object_irq_cond(cond), .ctrl_enable(en),
		.object_irq_req(req), .quantum_tick(tick), .rate_prescale_value(pre));
	// ------------------------------------------------
	// access tasks: one-cycle strobe, data one cycle later
	// ------------------------------------------------
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_req <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		sfr_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		sfr_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk);
		sfr_req <= '0;
		#1 chk(rdata, e);
	endtask
	// new object conditions, then let pending and request settle
	task automatic obj(input logic [14:0] c, input logic r);
		@(posedge ref_clk);
		cond <= c;
		repeat (3) @(posedge ref_clk);
		#1 chk({7'h00, req}, {7'h00, r});
	endtask
	task automatic conclude;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(CMI_ADDR_EN_LO, 8'h00);
		rd(CMI_ADDR_STAT_HI, 8'h00);
		wr(CMI_ADDR_EN_HI, 8'h7F);
		rd(CMI_ADDR_EN_HI, 8'h7F);
		wr(CMI_ADDR_EN_LO, 8'hA5);
		rd(CMI_ADDR_EN_LO, 8'hA5);
		obj(15'h2D5A, 1'b1);
		wr(CMI_ADDR_STAT_LO, 8'hFF);
		rd(CMI_ADDR_STAT_LO, 8'h5A);
		rd(CMI_ADDR_STAT_HI, 8'h2D);
		obj(15'h0002, 1'b0);
		obj(15'h0004, 1'b1);
		wr(CMI_ADDR_EN_LO, 8'h00);
		obj(15'h0004, 1'b0);
		obj(15'h0000, 1'b0);
		rd(CMI_ADDR_STAT_LO, 8'h00);
		$display("test objects done");
		wr(CMI_ADDR_PRESCALE, 8'h06);
		rd(CMI_ADDR_PRESCALE, 8'h06);
		@(posedge ref_clk);
		en <= 1'b1;
		n = 0;
		// a divide by four gives ten ticks in 42 clocks
		repeat (42)
		begin
			@(posedge ref_clk);
			#1 n += int'(tick === 1'b1);
		end
		chk(8'(n), 8'h0A);
		wr(CMI_ADDR_PRESCALE, 8'h0A);
		rd(CMI_ADDR_PRESCALE, 8'h06);
		chk({2'b00, pre}, 8'h03);
		rd(8'h00, 8'h00);
		$display("test prescaler done");
		conclude();
	end
	initial
	begin
		#20000;
		fail_count++;
		conclude();
	end
endmodule // cmi_top_tb
`default_nettype wire
